// ===== verilog/csrsw_defines.svh
// csrsw_defines.svh: offsets, field positions, reset values for special regs
// assumes inclusion by bare name from the special-register files
`ifndef CSRSW_DEFINES_SVH
`define CSRSW_DEFINES_SVH

// processor register selectors on the core's register port
`define CSRSW_SEL_IP        3'h0
`define CSRSW_SEL_ESP       3'h1
`define CSRSW_SEL_USP       3'h2
`define CSRSW_SEL_DTB       3'h3
`define CSRSW_SEL_PSW       3'h4

// status word field positions
`define CSRSW_PSW_C         0
`define CSRSW_PSW_T         1
`define CSRSW_PSW_L         2
`define CSRSW_PSW_U         3
`define CSRSW_PSW_F         5
`define CSRSW_PSW_Z         6
`define CSRSW_PSW_N         7
`define CSRSW_PSW_E         9
`define CSRSW_PSW_P         10
`define CSRSW_PSW_I         11

// writable status bits: 4, 8 and 12..15 held at zero
`define CSRSW_PSW_WMASK     16'h0eef
`define CSRSW_PSW_RESET     16'h0200
// exception stack pointer: bit 0 and bits 31..24 held at zero
`define CSRSW_ADDR_MASK     32'h00ff_fffe
`define CSRSW_ADDR_LIMIT    32'h00ff_ffff
`define CSRSW_IP_MASK       24'hff_fffe

`endif

// ===== verilog/csrsw_pkg.sv
// csrsw_pkg.sv: types shared by the special-register block
// assumes csrsw_defines.svh gives the numeric constants
package csrsw_pkg;

    typedef enum logic [1:0] {
        CSRSW_RUN,
        CSRSW_EXC
    } csrsw_mode_t;

    // compare / arithmetic flag bundle
    typedef struct packed {
        logic c;
        logic f;
        logic z;
        logic l;
        logic n;
    } csrsw_flags_t;

endpackage : csrsw_pkg

// ===== verilog/csrsw_alu_flags.sv
// csrsw_alu_flags.sv: flag evaluation for add, subtract and compare
// assumes operands valid in the cycle of use; purely combinational
`timescale 1ns/10ps
`include "csrsw_defines.svh"

module csrsw_alu_flags #(
    parameter int WIDTH = 16
) (
    input  wire logic [WIDTH-1:0]     op_first_i,
    input  wire logic [WIDTH-1:0]     op_second_i,
    input  wire logic                 is_sub_i,
    output csrsw_pkg::csrsw_flags_t   flags_o
);

    logic [WIDTH:0]   sum;
    logic [WIDTH-1:0] b_eff;

    always_comb begin
        b_eff = is_sub_i ? ~op_first_i : op_first_i;
        // second minus first for subtraction
        sum = {1'b0, op_second_i} + {1'b0, b_eff} + {{WIDTH{1'b0}}, is_sub_i};
        flags_o.c = is_sub_i ? ~sum[WIDTH] : sum[WIDTH]; // RULE8
        flags_o.f = (op_second_i[WIDTH-1] == b_eff[WIDTH-1])
                    && (sum[WIDTH-1] != op_second_i[WIDTH-1]); // RULE14
        flags_o.z = (op_second_i == op_first_i); // RULE13
        flags_o.l = (op_second_i < op_first_i); // RULE11
        flags_o.n = ($signed(op_second_i) < $signed(op_first_i)); // RULE12
    end

endmodule : csrsw_alu_flags

// ===== verilog/csrsw_special_regs.sv
// Function
// RULE1: 24-bit instruction pointer, bit zero reads zero
// RULE2: reset loads zero or chosen start value
// RULE3: warm reset saves pointer to low pair
// RULE4: exception stack pointer forced zeros, hardware use
// RULE5: user stack out of range raises trap
// RULE6: software writes dispatch base with zeros
// RULE7: status word bit layout, 4 and 8 zero
// RULE8: carry set on carry or borrow
// RULE9: trace traps each instruction, not in handlers
// RULE10: trace copied to pending, once per instruction
// RULE11: low flag from unsigned compare
// RULE12: negative flag from signed compare
// RULE13: zero flag on equal operands
// RULE14: flag bit reports arithmetic overflow
// RULE15: user bit picks stack, set/cleared by events; stack_ptr_sel_o always gives the user stack pointer
// RULE16: user stack access in user mode traps
// RULE17: maskable needs both enables; nonmaskable always
// RULE18: enable/disable instructions drive local enable
// RULE19: global enable cleared on irq, set on return
// RULE20: branch conditions evaluate the flags
// RULE21: reset clears status except local enable
// RULE22: warm reset copies status to register two
// RULE23: user stack pointer is 32 bits
// RULE24: writes to forced-zero bits ignored
//
// csrsw_special_regs.sv: special-purpose registers and status word of the core
// assumes the sequencer drives one-cycle strobes synchronous to clk_sys_i
`timescale 1ns/10ps
`include "csrsw_defines.svh"

module csrsw_special_regs #(
    parameter logic [23:0] START_ADDR = 24'h00_0000,
    parameter int          WIDTH      = 16
) (
    input  wire logic              clk_sys_i,
    input  wire logic              reset_i,
    input  wire logic              warm_reset_i,
    // instruction flow
    input  wire logic              instr_start_i,
    input  wire logic              instr_end_i,
    input  wire logic              ip_load_i,
    input  wire logic [23:0]       ip_value_i,
    // processor register port
    input  wire logic              preg_wr_i,
    input  wire logic              preg_rd_i,
    input  wire logic [2:0]        preg_sel_i,
    input  wire logic [31:0]       preg_wdata_i,
    output logic      [31:0]       preg_rdata_o,
    // instructions touching status
    input  wire logic              enable_irq_instr_i,
    input  wire logic              disable_irq_instr_i,
    input  wire logic              jump_to_user_instr_i,
    input  wire logic              exc_enter_i,
    input  wire logic              exc_is_irq_i,
    input  wire logic              exc_return_i,
    input  wire logic [15:0]       exc_restore_psw_i,
    input  wire logic              esp_push_i,
    input  wire logic              esp_pop_i,
    input  wire logic [2:0]        esp_step_i,
    // alu flag update
    input  wire logic              flag_upd_i,
    input  wire logic              flag_is_cmp_i,
    input  wire logic              flag_is_sub_i,
    input  wire logic [WIDTH-1:0]  op_first_i,
    input  wire logic [WIDTH-1:0]  op_second_i,
    // branch and stack
    input  wire logic [3:0]        cond_code_i,
    input  wire logic              stack_access_i,
    input  wire logic              irq_req_i,
    input  wire logic              nmi_req_i,
    output logic                   branch_taken_o,
    output logic      [31:0]       stack_ptr_sel_o,
    output logic                   stack_is_user_o,
    output logic                   irq_accept_o,
    output logic                   nmi_accept_o,
    output logic                   trace_trap_o,
    output logic                   illegal_address_trap_o,
    output logic                   undefined_op_trap_o,
    output logic      [23:0]       instruction_pointer_o,
    output logic      [31:0]       exception_stack_pointer_o,
    output logic      [31:0]       dispatch_table_base_o,
    output logic      [15:0]       processor_status_word_o,
    output logic                   gp_save_o,
    output logic      [31:0]       low_gp_register_pair_o,
    output logic      [15:0]       gp_register_two_o
);

    typedef struct packed {
        csrsw_pkg::csrsw_mode_t mode;
        logic [23:0]            ip;
        logic [31:0]            esp;
        logic [31:0]            user_stack_pointer;
        logic [31:0]            dtb;
        logic [15:0]            psw;
        logic                   save;
        logic [31:0]            pair;
        logic [15:0]            r2;
        logic [31:0]            rdata;
    } csrsw_state_t;

    csrsw_state_t              st_reg;
    csrsw_state_t              st_next;
    csrsw_pkg::csrsw_flags_t   alu_flags;
    logic                      user_mode;
    logic                      usp_denied;

    csrsw_alu_flags #(
        .WIDTH       (WIDTH)
    ) u_flags (
        .op_first_i  (op_first_i),
        .op_second_i (op_second_i),
        .is_sub_i    (flag_is_sub_i),
        .flags_o     (alu_flags)
    );

    function automatic logic cond_eval(input logic [3:0] cc, input logic [15:0] p);
        case (cc) // RULE20
            4'h0: cond_eval = p[`CSRSW_PSW_Z];
            4'h1: cond_eval = ~p[`CSRSW_PSW_Z];
            4'h2: cond_eval = p[`CSRSW_PSW_C];
            4'h3: cond_eval = ~p[`CSRSW_PSW_C];
            4'h4: cond_eval = p[`CSRSW_PSW_L];
            4'h5: cond_eval = ~p[`CSRSW_PSW_L];
            4'h6: cond_eval = p[`CSRSW_PSW_N];
            4'h7: cond_eval = ~p[`CSRSW_PSW_N];
            4'h8: cond_eval = p[`CSRSW_PSW_F];
            4'h9: cond_eval = ~p[`CSRSW_PSW_F];
            4'ha: cond_eval = ~p[`CSRSW_PSW_L] & ~p[`CSRSW_PSW_Z];
            4'hb: cond_eval = p[`CSRSW_PSW_L] | p[`CSRSW_PSW_Z];
            4'hc: cond_eval = ~p[`CSRSW_PSW_N] & ~p[`CSRSW_PSW_Z];
            4'hd: cond_eval = p[`CSRSW_PSW_N] | p[`CSRSW_PSW_Z];
            4'he: cond_eval = 1'b1;
            default: cond_eval = 1'b0;
        endcase
    endfunction : cond_eval

    assign user_mode  = st_reg.psw[`CSRSW_PSW_U];
    // user stack pointer is a supervisor-only register
    assign usp_denied = user_mode && (preg_wr_i || preg_rd_i)
                        && (preg_sel_i == `CSRSW_SEL_USP); // RULE16

    always_comb begin
        st_next      = st_reg;
        st_next.save = 1'b0;
        // instruction flow
        if (ip_load_i) begin
            st_next.ip = ip_value_i & `CSRSW_IP_MASK; // RULE1
        end
        // a new instruction's copy beats the old one's clear
        if (instr_end_i && trace_trap_o) begin
            st_next.psw[`CSRSW_PSW_P] = 1'b0; // RULE10
        end
        if (instr_start_i) begin
            st_next.psw[`CSRSW_PSW_P] = st_reg.psw[`CSRSW_PSW_T]; // RULE10
        end
        // alu flags
        if (flag_upd_i) begin
            if (flag_is_cmp_i) begin
                st_next.psw[`CSRSW_PSW_Z] = alu_flags.z; // RULE13
                st_next.psw[`CSRSW_PSW_L] = alu_flags.l; // RULE11
                st_next.psw[`CSRSW_PSW_N] = alu_flags.n; // RULE12
            end else begin
                st_next.psw[`CSRSW_PSW_C] = alu_flags.c; // RULE8
                st_next.psw[`CSRSW_PSW_F] = alu_flags.f; // RULE14
            end
        end
        if (enable_irq_instr_i) begin
            st_next.psw[`CSRSW_PSW_E] = 1'b1; // RULE18
        end
        if (disable_irq_instr_i) begin
            st_next.psw[`CSRSW_PSW_E] = 1'b0; // RULE18
        end
        if (jump_to_user_instr_i) begin
            st_next.psw[`CSRSW_PSW_U] = 1'b1; // RULE15
        end
        // software writes; forced-zero bits dropped
        if (preg_wr_i && !usp_denied) begin
            case (preg_sel_i)
                `CSRSW_SEL_ESP: st_next.esp = preg_wdata_i & `CSRSW_ADDR_MASK; // RULE24
                `CSRSW_SEL_USP: st_next.user_stack_pointer = preg_wdata_i; // RULE23
                `CSRSW_SEL_DTB: st_next.dtb = preg_wdata_i; // RULE6
                `CSRSW_SEL_PSW: begin
                    st_next.psw = preg_wdata_i[15:0] & `CSRSW_PSW_WMASK; // RULE24
                    // user mode cannot lift its own privilege through the status word
                    if (user_mode) begin
                        st_next.psw[`CSRSW_PSW_U] = 1'b1;
                    end
                end
                default: st_next.ip = st_next.ip;
            endcase
        end
        // hardware stack use
        if (esp_push_i) begin
            st_next.esp = (st_reg.esp - {29'h0, esp_step_i}) & `CSRSW_ADDR_MASK; // RULE4
        end else if (esp_pop_i) begin
            st_next.esp = (st_reg.esp + {29'h0, esp_step_i}) & `CSRSW_ADDR_MASK; // RULE4
        end
        // exception entry and return override
        if (exc_enter_i) begin
            st_next.mode = csrsw_pkg::CSRSW_EXC;
            st_next.psw[`CSRSW_PSW_U] = 1'b0; // RULE15
            st_next.psw[`CSRSW_PSW_T] = 1'b0; // RULE9
            st_next.psw[`CSRSW_PSW_P] = 1'b0; // RULE9
            if (exc_is_irq_i) begin
                st_next.psw[`CSRSW_PSW_I] = 1'b0; // RULE19
            end
        end else if (exc_return_i) begin
            st_next.mode = csrsw_pkg::CSRSW_RUN;
            st_next.psw  = exc_restore_psw_i & `CSRSW_PSW_WMASK;
            if (exc_is_irq_i) begin
                st_next.psw[`CSRSW_PSW_I] = 1'b1; // RULE19
            end
        end
        // read data
        case (preg_sel_i)
            `CSRSW_SEL_IP:  st_next.rdata = {8'h00, st_reg.ip};
            `CSRSW_SEL_ESP: st_next.rdata = st_reg.esp;
            `CSRSW_SEL_USP: st_next.rdata = usp_denied ? 32'h0000_0000 : st_reg.user_stack_pointer;
            `CSRSW_SEL_DTB: st_next.rdata = st_reg.dtb;
            `CSRSW_SEL_PSW: st_next.rdata = {16'h0000, st_reg.psw};
            default:        st_next.rdata = 32'h0000_0000;
        endcase
        // resets win over everything
        if (reset_i) begin
            st_next.mode = csrsw_pkg::CSRSW_RUN;
            st_next.ip   = START_ADDR & `CSRSW_IP_MASK; // RULE2
            st_next.psw  = `CSRSW_PSW_RESET; // RULE21
            st_next.rdata = 32'h0000_0000;
            if (warm_reset_i) begin
                st_next.save = 1'b1;
                st_next.pair = {8'h00, st_reg.ip}; // RULE3
                st_next.r2   = st_reg.psw; // RULE22
            end else begin
                st_next.esp  = 32'h0000_0000;
                st_next.user_stack_pointer  = 32'h0000_0000;
                st_next.dtb  = 32'h0000_0000;
                st_next.pair = 32'h0000_0000;
                st_next.r2   = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        st_reg <= st_next;
    end

    assign trace_trap_o = instr_end_i && st_reg.psw[`CSRSW_PSW_P]
                          && (st_reg.mode == csrsw_pkg::CSRSW_RUN); // RULE9
    // both enables gate maskable requests; nmi passes regardless
    assign irq_accept_o = irq_req_i && !nmi_req_i && st_reg.psw[`CSRSW_PSW_E]
                          && st_reg.psw[`CSRSW_PSW_I]; // RULE17
    assign nmi_accept_o = nmi_req_i; // RULE17
    assign stack_is_user_o = user_mode; // RULE15
    assign stack_ptr_sel_o = st_reg.user_stack_pointer;
    assign illegal_address_trap_o = stack_access_i && user_mode
                                    && (st_reg.user_stack_pointer > `CSRSW_ADDR_LIMIT); // RULE5
    assign undefined_op_trap_o = usp_denied; // RULE16
    assign branch_taken_o = cond_eval(cond_code_i, st_reg.psw); // RULE20
    assign preg_rdata_o = st_reg.rdata;
    assign instruction_pointer_o = st_reg.ip;
    assign exception_stack_pointer_o = st_reg.esp;
    assign dispatch_table_base_o = st_reg.dtb;
    assign processor_status_word_o = st_reg.psw; // RULE7
    assign gp_save_o = st_reg.save;
    assign low_gp_register_pair_o = st_reg.pair;
    assign gp_register_two_o = st_reg.r2;

    // reset checks stay live through reset, the rest sleep in it
    AST_IP_EVEN: assert property ( // RULE1
        @(posedge clk_sys_i) disable iff (reset_i)
        instruction_pointer_o[0] == 1'b0
    ) else $error("ip odd");

    AST_RESET_IP: assert property ( // RULE2
        @(posedge clk_sys_i)
        reset_i |=> instruction_pointer_o == (START_ADDR & 24'hff_fffe)
    ) else $error("ip not at start after reset");

    AST_WARM_PAIR: assert property ( // RULE3
        @(posedge clk_sys_i)
        (reset_i && warm_reset_i) |=> gp_save_o
        && low_gp_register_pair_o == {8'h00, $past(instruction_pointer_o)}
    ) else $error("warm reset ip not saved");

    AST_ESP_ZERO: assert property ( // RULE4
        @(posedge clk_sys_i) disable iff (reset_i)
        exception_stack_pointer_o[0] == 1'b0
        && exception_stack_pointer_o[31:24] == 8'h00
    ) else $error("esp forced bits set");

    AST_PSW_ZERO: assert property ( // RULE7
        @(posedge clk_sys_i) disable iff (reset_i)
        processor_status_word_o[4] == 1'b0
        && processor_status_word_o[8] == 1'b0
        && processor_status_word_o[15:12] == 4'h0
    ) else $error("psw zero bits set");

    AST_RESET_PSW: assert property ( // RULE21
        @(posedge clk_sys_i)
        reset_i |=> processor_status_word_o == 16'h0200
    ) else $error("psw reset");

    AST_WARM_R2: assert property ( // RULE22
        @(posedge clk_sys_i)
        (reset_i && warm_reset_i) |=> gp_register_two_o == $past(processor_status_word_o)
    ) else $error("warm reset psw not saved");

    AST_TRACE_COPY: assert property ( // RULE10
        @(posedge clk_sys_i) disable iff (reset_i)
        (instr_start_i && !exc_enter_i && !exc_return_i && !preg_wr_i)
        |=> processor_status_word_o[10] == $past(processor_status_word_o[1])
    ) else $error("pending not copied");

    AST_IRQ_GATE: assert property ( // RULE17
        @(posedge clk_sys_i) disable iff (reset_i)
        irq_accept_o |-> processor_status_word_o[9] && processor_status_word_o[11]
    ) else $error("irq taken while masked");

    AST_IRQ_CLR_I: assert property ( // RULE19
        @(posedge clk_sys_i) disable iff (reset_i)
        (exc_enter_i && exc_is_irq_i) |=> !processor_status_word_o[11]
        && !processor_status_word_o[3]
    ) else $error("irq entry state");

    AST_IRQ_SET_I: assert property ( // RULE19
        @(posedge clk_sys_i) disable iff (reset_i)
        (exc_return_i && exc_is_irq_i && !exc_enter_i)
        |=> processor_status_word_o[11]
    ) else $error("irq return state");

    AST_USP_TRAP: assert property ( // RULE5
        @(posedge clk_sys_i) disable iff (reset_i)
        (stack_access_i && stack_is_user_o && stack_ptr_sel_o[31:24] != 8'h00)
        |-> illegal_address_trap_o
    ) else $error("no illegal address trap");

    AST_LOCAL_EN: assert property ( // RULE18
        @(posedge clk_sys_i) disable iff (reset_i)
        (enable_irq_instr_i || disable_irq_instr_i) && !exc_return_i && !preg_wr_i
        |=> processor_status_word_o[9] == !$past(disable_irq_instr_i)
    ) else $error("local enable wrong");

endmodule : csrsw_special_regs

// ===== verification/csrsw_core_model.sv
// csrsw_core_model.sv: sequencer stand-in that frames one instruction per request
// assumes run_i is a one-cycle request from the bench, len_i the cycles between marks
`timescale 1ns/10ps

module csrsw_core_model (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    input  wire logic       run_i,
    input  wire logic [3:0] len_i,
    output logic            instr_start_o,
    output logic            instr_end_o,
    output logic            busy_o
);
    logic [3:0] cnt_reg = 4'h0;
    logic       start_reg = 1'b0;
    logic       end_reg = 1'b0;
    logic       busy_reg = 1'b0;

    assign instr_start_o = start_reg;
    assign instr_end_o   = end_reg;
    assign busy_o        = busy_reg;

    // len_i of zero gives a prompt instruction, larger values a slow one
    always_ff @(posedge clk_sys_i) begin
        start_reg <= 1'b0;
        end_reg   <= 1'b0;
        if (reset_i) begin
            busy_reg <= 1'b0;
            cnt_reg  <= 4'h0;
        end else if (!busy_reg && run_i) begin
            busy_reg  <= 1'b1;
            start_reg <= 1'b1;
            cnt_reg   <= len_i;
        end else if (busy_reg) begin
            if (cnt_reg == 4'h0) begin
                end_reg  <= 1'b1;
                busy_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end
endmodule : csrsw_core_model

// ===== verification/csrsw_special_regs_bench.sv
// csrsw_special_regs_bench.sv: self-checking bench for the special-register block
// assumes csrsw_core_model frames instructions; the bench drives every other strobe
`timescale 1ns/10ps
`include "csrsw_defines.svh"

module csrsw_special_regs_bench;
    localparam logic [23:0] START = 24'h00_1000;
    logic        clk_sys_i = 1'b0, reset_i = 1'b1, warm_reset_i = 1'b0, run = 1'b0;
    logic        instr_start_i, instr_end_i, busy, rd_q = 1'b0;
    logic [3:0]  len = 4'h2, cond_code_i = 4'h0;
    logic        preg_wr_i = 1'b0, preg_rd_i = 1'b0, exc_is_irq_i = 1'b0;
    logic [23:0] ip_value_i = 24'h0, instruction_pointer_o;
    logic [2:0]  preg_sel_i = 3'h0, esp_step_i = 3'h0;
    logic [31:0] preg_wdata_i = 32'h0, preg_rdata_o, stack_ptr_sel_o;
    logic [31:0] exception_stack_pointer_o, dispatch_table_base_o, low_gp_register_pair_o;
    // strobes: 0 ei, 1 di, 2 user jump, 3 enter, 4 return, 5 push, 6 pop, 7 ip load, 8 flags
    logic [8:0]  ev = 9'h000;
    logic [15:0] exc_restore_psw_i = 16'h0, op_first_i = 16'h0, op_second_i = 16'h0;
    logic [15:0] processor_status_word_o, gp_register_two_o;
    logic        flag_is_cmp_i = 1'b0, flag_is_sub_i = 1'b0;
    logic        stack_access_i = 1'b0, irq_req_i = 1'b0, nmi_req_i = 1'b0;
    logic        branch_taken_o, stack_is_user_o, irq_accept_o, nmi_accept_o, trace_trap_o;
    logic        illegal_address_trap_o, undefined_op_trap_o, gp_save_o;
    logic        e_c = 1'b0, e_f = 1'b0, e_z = 1'b0, e_l = 1'b0, e_n = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] u;
    int          num_errors = 0, checks = 0;

    csrsw_special_regs #(.START_ADDR(START)) u_dut (
        .clk_sys_i, .reset_i, .warm_reset_i, .instr_start_i, .instr_end_i,
        .ip_load_i(ev[7]), .ip_value_i, .preg_wr_i, .preg_rd_i, .preg_sel_i, .preg_wdata_i,
        .preg_rdata_o, .enable_irq_instr_i(ev[0]), .disable_irq_instr_i(ev[1]),
        .jump_to_user_instr_i(ev[2]), .exc_enter_i(ev[3]), .exc_is_irq_i,
        .exc_return_i(ev[4]), .exc_restore_psw_i, .esp_push_i(ev[5]), .esp_pop_i(ev[6]),
        .esp_step_i, .flag_upd_i(ev[8]), .flag_is_cmp_i, .flag_is_sub_i, .op_first_i,
        .op_second_i, .cond_code_i, .stack_access_i, .irq_req_i, .nmi_req_i, .branch_taken_o,
        .stack_ptr_sel_o, .stack_is_user_o, .irq_accept_o, .nmi_accept_o, .trace_trap_o,
        .illegal_address_trap_o, .undefined_op_trap_o, .instruction_pointer_o,
        .exception_stack_pointer_o, .dispatch_table_base_o, .processor_status_word_o,
        .gp_save_o, .low_gp_register_pair_o, .gp_register_two_o
    );

    csrsw_core_model u_core (.clk_sys_i, .reset_i, .run_i(run), .len_i(len),
        .instr_start_o(instr_start_i), .instr_end_o(instr_end_i), .busy_o(busy));

    always #25 clk_sys_i = ~clk_sys_i;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("comparisons=%0d mismatches=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : tick

    task automatic pulse(input logic [8:0] m);
        ev <= m;
        tick(1);
        ev <= 9'h000;
        tick(1);
    endtask : pulse

    task automatic wr(input logic [2:0] s, input logic [31:0] d);
        preg_wr_i    <= 1'b1;
        preg_sel_i   <= s;
        preg_wdata_i <= d;
        tick(1);
        preg_wr_i <= 1'b0;
        tick(1);
    endtask : wr

    // read data is judged by the monitor one edge later; the refusal flag right here
    task automatic rd(input logic [2:0] s, input logic [31:0] e, input logic t);
        preg_rd_i  <= 1'b1;
        preg_sel_i <= s;
        exp_q.push_back(e);
        tick(1);
        check(undefined_op_trap_o, t);
        preg_rd_i <= 1'b0;
        tick(2);
    endtask : rd

    always @(posedge clk_sys_i) begin
        rd_q <= preg_rd_i & ~reset_i;
        if (rd_q && exp_q.size() > 0) begin
            check(preg_rdata_o, exp_q.pop_front());
        end
    end

    task automatic flags(input logic [15:0] a, input logic [15:0] b, input logic cmp,
                         input logic sub);
        logic [16:0] s;
        logic [15:0] t;
        s = sub ? {1'b0, b} - {1'b0, a} : {1'b0, a} + {1'b0, b};
        op_first_i    <= a;
        op_second_i   <= b;
        flag_is_cmp_i <= cmp;
        flag_is_sub_i <= sub;
        pulse(9'h100);
        if (cmp) begin
            e_z = (a == b);
            e_l = (b < a);
            e_n = ($signed(b) < $signed(a));
        end else begin
            e_c = s[16];
            e_f = sub ? (a[15] != b[15]) && (s[15] != b[15])
                : (a[15] == b[15]) && (s[15] != a[15]);
        end
        check(processor_status_word_o[6], e_z);
        check(processor_status_word_o[2], e_l);
        check(processor_status_word_o[7], e_n);
        check(processor_status_word_o[0], e_c);
        check(processor_status_word_o[5], e_f);
        t = {1'b0, 1'b1, e_n | e_z, !e_n & !e_z, e_l | e_z, !e_l & !e_z, !e_f, e_f,
             !e_n, e_n, !e_l, e_l, !e_c, e_c, !e_z, e_z};
        for (int c = 0; c < 16; c++) begin
            cond_code_i <= c[3:0];
            tick(1);
            check(branch_taken_o, t[c]);
        end
    endtask : flags

    task automatic instr(input logic exp);
        int n;
        n = 0;
        run <= 1'b1;
        tick(1);
        run <= 1'b0;
        while (instr_end_i !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        if (instr_end_i !== 1'b1) begin
            num_errors++;
            results();
        end
        check(trace_trap_o, exp);
        tick(2);
    endtask : instr

    initial begin
        void'($urandom(84629));
        tick(8);
        reset_i <= 1'b0;
        tick(1);
        rd(`CSRSW_SEL_IP, {8'h00, START}, 1'b0);
        rd(`CSRSW_SEL_PSW, 32'h0000_0200, 1'b0);
        wr(`CSRSW_SEL_ESP, 32'hffff_ffff);
        rd(`CSRSW_SEL_ESP, 32'h00ff_fffe, 1'b0);
        esp_step_i <= 3'h4;
        pulse(9'h020);
        check(exception_stack_pointer_o, 32'h00ff_fffa);
        pulse(9'h040);
        check(exception_stack_pointer_o, 32'h00ff_fffe);
        u = $urandom();
        wr(`CSRSW_SEL_USP, u);
        rd(`CSRSW_SEL_USP, u, 1'b0);
        wr(`CSRSW_SEL_DTB, {8'h00, u[23:1], 1'b0});
        check(dispatch_table_base_o, {8'h00, u[23:1], 1'b0});
        wr(`CSRSW_SEL_PSW, 32'h0000_ffff);
        rd(`CSRSW_SEL_PSW, 32'h0000_0eef, 1'b0);
        exc_restore_psw_i <= 16'h0200;
        pulse(9'h008);
        pulse(9'h010);
        ip_value_i <= 24'hab_cdef;
        pulse(9'h080);
        check(instruction_pointer_o, 24'hab_cdee);
        $display("test registers done");
        for (int i = 0; i < 12; i++) begin
            u = $urandom();
            flags(u[15:0], (i < 2) ? u[15:0] : u[31:16], i[0], i[1]);
        end
        flags(16'hffff, 16'h0001, 1'b0, 1'b0);
        flags(16'h7fff, 16'h0001, 1'b0, 1'b0);
        flags(16'h0001, 16'h8000, 1'b0, 1'b1);
        $display("test flags done");
        irq_req_i <= 1'b1;
        wr(`CSRSW_SEL_PSW, 32'h0000_0a00);
        check(irq_accept_o, 1'b1);
        pulse(9'h002);
        check(irq_accept_o, 1'b0);
        pulse(9'h001);
        check(irq_accept_o, 1'b1);
        nmi_req_i <= 1'b1;
        tick(1);
        check(nmi_accept_o, 1'b1);
        nmi_req_i    <= 1'b0;
        exc_is_irq_i <= 1'b1;
        pulse(9'h008);
        check(processor_status_word_o[11], 1'b0);
        check(irq_accept_o, 1'b0);
        pulse(9'h010);
        check(processor_status_word_o[11], 1'b1);
        exc_is_irq_i <= 1'b0;
        irq_req_i    <= 1'b0;
        $display("test interrupts done");
        wr(`CSRSW_SEL_USP, 32'h0100_0000);
        pulse(9'h004);
        check(stack_is_user_o, 1'b1);
        stack_access_i <= 1'b1;
        tick(1);
        check(illegal_address_trap_o, 1'b1);
        check(stack_ptr_sel_o, 32'h0100_0000);
        rd(`CSRSW_SEL_USP, 32'h0, 1'b1);
        pulse(9'h008);
        check(stack_is_user_o, 1'b0);
        check(illegal_address_trap_o, 1'b0);
        stack_access_i <= 1'b0;
        pulse(9'h010);
        $display("test user mode done");
        wr(`CSRSW_SEL_PSW, 32'h0000_0202);
        instr(1'b1);
        pulse(9'h008);
        wr(`CSRSW_SEL_PSW, 32'h0000_0202);
        len <= 4'h0;
        instr(1'b0);
        pulse(9'h010);
        $display("test trace done");
        wr(`CSRSW_SEL_PSW, 32'h0000_0a65);
        reset_i      <= 1'b1;
        warm_reset_i <= 1'b1;
        tick(1);
        reset_i      <= 1'b0;
        warm_reset_i <= 1'b0;
        for (int i = 0; i < 4 && gp_save_o !== 1'b1; i++) tick(1);
        if (gp_save_o !== 1'b1) begin
            num_errors++;
            results();
        end
        check(low_gp_register_pair_o, 32'h00ab_cdee);
        check(gp_register_two_o, 16'h0a65);
        rd(`CSRSW_SEL_IP, {8'h00, START}, 1'b0);
        rd(`CSRSW_SEL_PSW, 32'h0000_0200, 1'b0);
        $display("test warm reset done");
        results();
    end
endmodule : csrsw_special_regs_bench
